// File: pkg/shift_pattern_defs.svh
`ifndef SHIFT_PATTERN_DEFS_SVH
`define SHIFT_PATTERN_DEFS_SVH

// stages in each of the two shift registers
`define SHIFT_STAGES 8
// reset fill bit of both registers
`define SHIFT_RESET_BIT 1'h0
// position of register A and B within the stage output bus
`define STAGE_A_LSB 0
`define STAGE_B_LSB 8
// positions within the synchronised pin vector
`define PIN_STEP 0
`define PIN_RANDOM 1
`define PIN_CHAINED 2
`define PIN_RANDOM_SRC 3
`define PIN_INVERT 4
`define PIN_COUNT 5

`endif

// File: pkg/shift_pattern_pkg.sv
package shift_pattern_pkg;

	// ring topology chosen by the mode switch
	typedef enum logic {
		DUAL_RING_MODE,
		CHAINED_RING_MODE
	} ring_mode_t;

	// where register A takes its serial input from
	typedef enum logic {
		SRC_PATTERN,
		SRC_RANDOM
	} a_source_t;

endpackage

// File: hw/pin_sync.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// two-stage synchroniser for asynchronous panel pins
// ------------------------------------------------------------
module pin_sync #(
	parameter int WIDTH = 1
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// a zero-width synchroniser cannot carry anything
	generate
		if (WIDTH < 1)
		begin : g_width_check
			$error("pin_sync width must be at least one");
		end
	endgenerate

	// first flop only feeds the second, never any logic
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= pin_in;
			sync_reg <= meta_reg;
		end
	end

	assign pin_out = sync_reg;

endmodule

// File: hw/dual_recirculating_shift_pattern.sv
`timescale 1ns/1ps
`include "shift_pattern_defs.svh"
module dual_recirculating_shift_pattern #(
	parameter int STAGES = `SHIFT_STAGES
)
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic step_clock,
	input wire logic random_bit,
	input wire logic chained_ring_mode,
	input wire logic random_source,
	input wire logic invert_b,
	output logic [2*STAGES-1:0] stage_bits
);
	import shift_pattern_pkg::*;

	localparam int CNT_W = (STAGES > 2) ? $clog2(STAGES) : 1;
	localparam logic [CNT_W-1:0] LAST_STEP = CNT_W'(STAGES - 1);

	// ------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------
	generate
		if (STAGES < 2)
		begin : g_stage_check
			$error("each shift register needs at least two stages");
		end
	endgenerate

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n_sync;

	// async assert, release through two flops to avoid skewed exit
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_reg <= 1'h0;
			rst_n_sync <= 1'h0;
		end
		else
		begin
			rst_meta_reg <= 1'h1;
			rst_n_sync <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------
	logic [`PIN_COUNT-1:0] pins_raw;
	logic [`PIN_COUNT-1:0] pins_s;

	// all pins share one latency, so random bit and step edge stay aligned
	assign pins_raw[`PIN_STEP] = step_clock;
	assign pins_raw[`PIN_RANDOM] = random_bit;
	assign pins_raw[`PIN_CHAINED] = chained_ring_mode;
	assign pins_raw[`PIN_RANDOM_SRC] = random_source;
	assign pins_raw[`PIN_INVERT] = invert_b;

	pin_sync #(
		.WIDTH(`PIN_COUNT)
	) u_pin_sync (
		.clock(clock),
		.rst_n(rst_n_sync),
		.pin_in(pins_raw),
		.pin_out(pins_s)
	);

	ring_mode_t mode_s;
	a_source_t source_s;
	logic invert_s;
	logic random_s;

	assign mode_s = ring_mode_t'(pins_s[`PIN_CHAINED]);
	assign source_s = a_source_t'(pins_s[`PIN_RANDOM_SRC]);
	assign invert_s = pins_s[`PIN_INVERT];
	assign random_s = pins_s[`PIN_RANDOM];

	// ------------------------------------------------------------
	// step edge detection
	// ------------------------------------------------------------
	logic step_prev_reg;
	logic step_prev_next;
	logic step_pulse;

	// one-cycle enable on each rising edge of the step clock
	assign step_pulse = pins_s[`PIN_STEP] & ~step_prev_reg;

	always_comb
	begin
		step_prev_next = pins_s[`PIN_STEP];
	end

	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
			step_prev_reg <= 1'h0;
		else
			step_prev_reg <= step_prev_next;
	end

	// ------------------------------------------------------------
	// serial input routing
	// ------------------------------------------------------------
	// returns {a_in, b_in}; b's tail is complemented when inv is set, before any reuse
	function automatic logic [1:0] feed_inputs(
		input ring_mode_t mode,
		input a_source_t src,
		input logic inv,
		input logic a_last,
		input logic b_last,
		input logic rnd
	);
		logic b_out;
		logic a_in;
		logic b_in;
		b_out = b_last ^ inv;
		if (src == SRC_RANDOM)
			a_in = rnd;
		else if (mode == DUAL_RING_MODE)
			a_in = a_last;
		else
			a_in = b_out;
		b_in = (mode == DUAL_RING_MODE) ? b_out : a_last;
		return {a_in, b_in};
	endfunction

	logic [STAGES-1:0] shift_a_reg;
	logic [STAGES-1:0] shift_a_next;
	logic [STAGES-1:0] shift_b_reg;
	logic [STAGES-1:0] shift_b_next;
	logic [1:0] feed;

	// source picks A input
	// settings are read live, so a switch flip acts on the next shift
	assign feed = feed_inputs(mode_s, source_s, invert_s, shift_a_reg[STAGES-1],
		shift_b_reg[STAGES-1], random_s);

	// ------------------------------------------------------------
	// shift registers
	// ------------------------------------------------------------
	// capture only on step
	always_comb
	begin
		shift_a_next = shift_a_reg;
		shift_b_next = shift_b_reg;
		if (step_pulse)
		begin
			// stage one is bit 0; last stage leaves, routed by feed
			shift_a_next = {shift_a_reg[STAGES-2:0], feed[1]};
			shift_b_next = {shift_b_reg[STAGES-2:0], feed[0]};
		end
	end

	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			shift_a_reg <= {STAGES{`SHIFT_RESET_BIT}};
			shift_b_reg <= {STAGES{`SHIFT_RESET_BIT}};
		end
		else
		begin
			shift_a_reg <= shift_a_next;
			shift_b_reg <= shift_b_next;
		end
	end

	assign stage_bits = {shift_b_reg, shift_a_reg};

	// ------------------------------------------------------------
	// helper for the complement check
	// ------------------------------------------------------------
	logic [CNT_W-1:0] help_cnt_reg;
	logic [CNT_W-1:0] help_cnt_next;
	logic [STAGES-1:0] help_snap_reg;
	logic [STAGES-1:0] help_snap_next;
	logic help_run_reg;
	logic help_run_next;
	logic help_cond;

	// B loops through the inverter in dual mode regardless of source
	assign help_cond = (mode_s == DUAL_RING_MODE) && invert_s;

	always_comb
	begin
		help_cnt_next = help_cnt_reg;
		help_snap_next = help_snap_reg;
		help_run_next = help_run_reg;
		if (step_pulse)
		begin
			if (!help_cond)
			begin
				help_run_next = 1'h0;
				help_cnt_next = '0;
			end
			else
			begin
				if (help_cnt_reg == '0)
				begin
					help_snap_next = shift_b_reg;
					help_run_next = 1'h1;
				end
				help_cnt_next = (help_cnt_reg == LAST_STEP) ? '0 : help_cnt_reg + 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n_sync)
	begin
		if (!rst_n_sync)
		begin
			help_cnt_reg <= '0;
			help_snap_reg <= '0;
			help_run_reg <= 1'h0;
		end
		else
		begin
			help_cnt_reg <= help_cnt_next;
			help_snap_reg <= help_snap_next;
			help_run_reg <= help_run_next;
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n_sync);

	hold_between_steps_a: assert property (!step_pulse |=> $stable(shift_a_reg) && $stable(shift_b_reg))
		else $error("shift contents changed without a step edge");

	shift_body_a: assert property (step_pulse |=> shift_a_reg[STAGES-1:1] == $past(shift_a_reg[STAGES-2:0]))
		else $error("register A did not advance by one stage");

	random_into_a_a: assert property (step_pulse && source_s == SRC_RANDOM
		|=> shift_a_reg[0] == $past(random_s))
		else $error("register A did not take the comparator bit");

	dual_b_loop_a: assert property (step_pulse && mode_s == DUAL_RING_MODE
		|=> shift_b_reg[0] == ($past(shift_b_reg[STAGES-1]) ^ $past(invert_s)))
		else $error("register B did not recirculate its tail");

	chained_a_to_b_a: assert property (step_pulse && mode_s == CHAINED_RING_MODE
		|=> shift_b_reg[0] == $past(shift_a_reg[STAGES-1]))
		else $error("register A tail did not cross into B");

	chained_rand_inv_a: assert property (step_pulse && mode_s == CHAINED_RING_MODE
		&& source_s == SRC_RANDOM && invert_s |=> stage_bits[`STAGE_A_LSB] == $past(random_s))
		else $error("inversion leaked into chained random operation");

	dual_a_loop_a: assert property (step_pulse && mode_s == DUAL_RING_MODE && source_s == SRC_PATTERN
		|=> shift_a_reg[0] == $past(shift_a_reg[STAGES-1]))
		else $error("register A did not loop its own tail unchanged");

	chained_b_to_a_a: assert property (step_pulse && mode_s == CHAINED_RING_MODE && source_s == SRC_PATTERN
		|=> shift_a_reg[0] == ($past(shift_b_reg[STAGES-1]) ^ $past(invert_s)))
		else $error("register B tail did not close the chained ring");

	complement_pass_a: assert property (step_pulse && help_cond && help_run_reg && help_cnt_reg == LAST_STEP
		|=> shift_b_reg == ~help_snap_reg)
		else $error("inverted ring did not return the complement");

	stage_map_a: assert property (step_pulse && mode_s == CHAINED_RING_MODE
		|=> stage_bits[`STAGE_B_LSB] == $past(stage_bits[`STAGE_B_LSB-1]))
		else $error("stage nine did not follow stage eight");

	// main scenarios
	dual_random_c: cover property (step_pulse && mode_s == DUAL_RING_MODE && source_s == SRC_RANDOM);
	chained_random_c: cover property (step_pulse && mode_s == CHAINED_RING_MODE
		&& source_s == SRC_RANDOM);
	chained_invert_c: cover property (step_pulse && mode_s == CHAINED_RING_MODE && source_s == SRC_PATTERN
		&& invert_s);
	complement_seen_c: cover property (step_pulse && help_cond && help_run_reg && help_cnt_reg == LAST_STEP);
	mode_flip_c: cover property (step_pulse && mode_s == DUAL_RING_MODE ##[1:50] step_pulse
		&& mode_s == CHAINED_RING_MODE);

endmodule

// File: tb/panel_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// panel switches and comparator bit source
// ------------------------------------------------------------
module panel_model
(
	input wire logic clock,
	output logic step_clock,
	output logic random_bit,
	output logic chained_ring_mode,
	output logic random_source,
	output logic invert_b
);
	// all pins quiet at time zero, step low so the first rise is real
	initial
	begin
		step_clock = 1'h0;
		random_bit = 1'h0;
		chained_ring_mode = 1'h0;
		random_source = 1'h0;
		invert_b = 1'h0;
	end

	// switches move on a falling edge, well clear of any step
	task automatic set_sw(input logic m, input logic s, input logic i);
		@(negedge clock);
		chained_ring_mode = m;
		random_source = s;
		invert_b = i;
	endtask

	// one step: bit set up while low, held over the whole high phase
	task automatic pulse(input logic rbit);
		@(negedge clock);
		random_bit = rbit;
		repeat (3) @(negedge clock);
		step_clock = 1'h1;
		repeat (4) @(negedge clock);
		step_clock = 1'h0;
		// comparator keeps moving after the edge, like the real thing
		random_bit = ~rbit;
	endtask

	// comparator toggles with no step rise at all
	task automatic wiggle(input int n);
		repeat (n)
		begin
			@(negedge clock);
			random_bit = ~random_bit;
		end
	endtask
endmodule

// File: tb/dual_recirculating_shift_pattern_tb.sv
`timescale 1ns/1ps
module dual_recirculating_shift_pattern_tb;
	logic clock, resetn, step_clock, random_bit, chained_ring_mode, random_source, invert_b;
	logic [15:0] stage_bits;
	logic [7:0] a_exp, b_exp;
	logic [15:0] snap;
	int error_cnt, cmp_count;

	// ------------------------------------------------------------
	// clock, partner and design
	// ------------------------------------------------------------
	initial clock = 1'h0;
	always #25 clock = ~clock;

	panel_model panel (.clock(clock), .step_clock(step_clock), .random_bit(random_bit),
		.chained_ring_mode(chained_ring_mode), .random_source(random_source), .invert_b(invert_b));

	dual_recirculating_shift_pattern #(.STAGES(8)) uut (.clock(clock), .resetn(resetn),
		.step_clock(step_clock), .random_bit(random_bit), .chained_ring_mode(chained_ring_mode),
		.random_source(random_source), .invert_b(invert_b), .stage_bits(stage_bits));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize;
		$display("compares=%0d errors=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one step, with the reference routing worked out before the shift
	task automatic step(input logic rbit);
		logic a_in, b_in, b_tail;
		b_tail = b_exp[7] ^ invert_b;
		a_in = random_source ? rbit : (chained_ring_mode ? b_tail : a_exp[7]);
		b_in = chained_ring_mode ? a_exp[7] : b_tail;
		panel.pulse(rbit);
		a_exp = {a_exp[6:0], a_in};
		b_exp = {b_exp[6:0], b_in};
		check(stage_bits, {b_exp, a_exp});
	endtask

	// switch change alone must leave stored bits alone
	task automatic mode(input logic m, input logic s, input logic i);
		panel.set_sw(m, s, i);
		repeat (6) @(negedge clock);
		check(stage_bits, {b_exp, a_exp});
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	// dual random: A fills from comparator, B loops zeros
	task automatic sc_load;
		logic [7:0] pat;
		pat = 8'h99;
		mode(1'h0, 1'h1, 1'h0);
		for (int i = 7; i >= 0; i--)
			step(pat[i]);
		check(stage_bits, 16'h0099);
	endtask

	// level without a rise takes nothing in
	task automatic sc_no_rise;
		panel.wiggle(20);
		check(stage_bits, {b_exp, a_exp});
	endtask

	// chained random, invert on: A crosses into B unchanged, B tail lost
	task automatic sc_chain_rand;
		logic [7:0] pat;
		pat = 8'hC3;
		mode(1'h1, 1'h1, 1'h1);
		for (int i = 7; i >= 0; i--)
			step(pat[i]);
		check(stage_bits, 16'h99C3);
	endtask

	// dual pattern, invert on: A period 8, B complements each pass
	task automatic sc_dual_pat_inv;
		mode(1'h0, 1'h0, 1'h1);
		snap = {b_exp, a_exp};
		repeat (8) step(1'h1);
		check(stage_bits, {~snap[15:8], snap[7:0]});
		repeat (8) step(1'h0);
		check(stage_bits, snap);
	endtask

	// chained pattern, invert on: complement at 16, repeat at 32
	task automatic sc_chain_pat_inv;
		mode(1'h1, 1'h0, 1'h1);
		snap = {b_exp, a_exp};
		repeat (16) step(1'h1);
		check(stage_bits, ~snap);
		repeat (16) step(1'h0);
		check(stage_bits, snap);
	endtask

	// dual random, invert on: B repeats every 16 while A takes bits
	task automatic sc_dual_rand_inv;
		mode(1'h0, 1'h1, 1'h1);
		snap = {b_exp, a_exp};
		for (int i = 0; i < 8; i++)
			step(i[0]);
		check({8'h00, stage_bits[15:8]}, {8'h00, ~snap[15:8]});
		for (int i = 0; i < 8; i++)
			step(i[1]);
		check({8'h00, stage_bits[15:8]}, {8'h00, snap[15:8]});
	endtask

	// hang guard
	initial
	begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		summarize();
	end

	initial
	begin
		error_cnt = 0;
		cmp_count = 0;
		a_exp = 8'h00;
		b_exp = 8'h00;
		resetn = 1'h0;
		repeat (16) @(negedge clock);
		resetn = 1'h1;
		repeat (6) @(negedge clock);
		check(stage_bits, 16'h0000);
		sc_load();
		sc_no_rise();
		sc_chain_rand();
		sc_dual_pat_inv();
		sc_chain_pat_inv();
		sc_dual_rand_inv();
		summarize();
	end
endmodule
